// File: verilog/tsc_pkg.sv
package tsc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_MIN_NS = 90;
    localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOOT_TIME_NS = 21_200_000;
    localparam int BOOT_CYCLES = BOOT_TIME_NS / CLK_PERIOD_NS;
    localparam int SOFT_RESET_NS = 21_700_000;
    localparam int SOFT_RESET_CYCLES = SOFT_RESET_NS / CLK_PERIOD_NS;
    localparam int CHG_INPUT_NS = 100_000_000;
    localparam int CHG_INPUT_CYCLES = CHG_INPUT_NS / CLK_PERIOD_NS;
    localparam int XLINE_MAX_NS = 5_000_000;
    localparam int XLINE_MAX_CYCLES = XLINE_MAX_NS / CLK_PERIOD_NS;
    localparam int TICK_NS = 1_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_XEN = 12'h004;
    localparam logic [11:0] ADDR_YEN = 12'h008;
    localparam logic [11:0] ADDR_THR = 12'h00C;
    localparam logic [11:0] ADDR_AUTOCAL = 12'h010;
    localparam logic [11:0] ADDR_IDLE = 12'h014;
    localparam logic [11:0] ADDR_ACTIVE = 12'h018;
    localparam logic [11:0] ADDR_A2I = 12'h01C;
    localparam logic [11:0] ADDR_CSUM = 12'h020;
    localparam logic [11:0] ADDR_STATUS = 12'h024;
    localparam logic [15:0] XEN_RST = 16'hFFFF;
    localparam logic [13:0] YEN_RST = 14'h3FFF;
    localparam logic [7:0] THR_RST = 8'h20;
    localparam logic [7:0] AUTOCAL_RST = 8'h00;
    localparam logic [7:0] IDLE_RST = 8'h20;
    localparam logic [7:0] ACTIVE_RST = 8'h10;
    localparam logic [7:0] A2I_RST = 8'h32;
    localparam logic [15:0] CSUM_RST = XEN_RST ^ {2'b00, YEN_RST} ^ {THR_RST, AUTOCAL_RST}
        ^ {IDLE_RST, ACTIVE_RST} ^ {8'h00, A2I_RST};
    localparam int CTRL_SRST_BIT = 0;
    localparam int CTRL_RECAL_BIT = 1;
    localparam int ST_RESET = 0;
    localparam int ST_CFGERR = 1;
    localparam int ST_CALSTART = 2;
    localparam int ST_CALDONE = 3;
    localparam int ST_OVERRUN = 4;
    localparam int ST_FLAGS_W = 5;
    typedef enum logic [3:0] {
        S_BOOT = 4'b0001,
        S_SLEEP = 4'b0010,
        S_MEAS = 4'b0100,
        S_WAIT = 4'b1000
    } tsc_state_t;
endpackage : tsc_pkg

// File: verilog/tsc_scan_ctrl.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// Operation
// - measure one X line against all Y lines, then move to the next X
// - disabled X or Y channels are never measured
// - one screen-wide threshold decides when a channel is in detect
// - reset low for 90 ns or longer gives a full reset
// - device accepts communication about 21.2 ms after reset release
// - soft reset lasts about 21.7 ms, then change line is asserted
// - every completed reset sets the reset indication flag
// - configuration checksum mismatch sets the configuration error flag
// - change line stays an input for about 100 ms after reset
// - calibrate at power-up and when a channel becomes enabled
// - detect held longer than auto calibration time forces calibration
// - anti-touch delta beyond threshold with no touches forces calibration
// - a recalibrate command starts a calibration
// - status messages mark calibration start and completion
// - calibration always covers all channels together
// - one X line acquisition never exceeds 5 ms
// - active mode while touched, idle mode when untouched
// - both modes repeat burst then sleep, length from interval settings
// - timeout setting governs fall back from active to idle
// - change line is open drain and signals pending messages
module tsc_scan_ctrl #(
    parameter int BOOT_CYCLES = tsc_pkg::BOOT_CYCLES,
    parameter int SOFT_CYCLES = tsc_pkg::SOFT_RESET_CYCLES,
    parameter int CHG_IN_CYCLES = tsc_pkg::CHG_INPUT_CYCLES,
    parameter int XLINE_CYCLES = tsc_pkg::XLINE_MAX_CYCLES,
    parameter int TICK_CYCLES = tsc_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // measurement engine
    output logic meas_req,
    output logic [4:0] meas_x,
    output logic [4:0] meas_y,
    output logic meas_cal,
    input wire logic meas_valid,
    input wire logic signed [15:0] meas_delta,
    // change interrupt pin, open drain
    input wire logic change_interrupt_n_in,
    output logic change_interrupt_n_out,
    output logic change_interrupt_n_oe,
    // status
    output logic comm_ready,
    output logic active_mode
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    tsc_pkg::tsc_state_t state_reg, state_next;
    logic [31:0] boot_cnt_reg, tick_cnt_reg, line_cnt_reg, chg_win_reg;
    logic [15:0] xen_reg, scan_xen_reg, csum_reg;
    logic [13:0] yen_reg, scan_yen_reg;
    logic [7:0] thr_reg, autocal_reg, idle_reg, active_reg_int, a2i_reg;
    logic [7:0] sleep_cnt_reg, hold_cnt_reg, a2i_cnt_reg;
    logic [4:0] x_reg, y_reg;
    logic [tsc_pkg::ST_FLAGS_W-1:0] flag_reg, flag_set, flag_clr;
    logic [31:0] prdata_reg, rd_data, status_word;
    logic ready_reg, active_reg, cal_pend_reg, burst_cal_reg;
    logic burst_touch_reg, burst_anti_reg;

    function automatic logic [5:0] first_from(input logic [31:0] mask,
                                              input logic [5:0] from);
        logic [5:0] idx;
        idx = 6'h20;
        for (int i = 31; i >= 0; i--) begin
            if (mask[i] && (i >= int'(from))) begin
                idx = 6'(i);
            end
        end
        return idx;
    endfunction : first_from

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic setup = psel & ~penable;
    wire logic access = psel & penable;
    wire logic hit_ctrl = paddr == tsc_pkg::ADDR_CTRL;
    wire logic hit_xen = paddr == tsc_pkg::ADDR_XEN;
    wire logic hit_yen = paddr == tsc_pkg::ADDR_YEN;
    wire logic hit_thr = paddr == tsc_pkg::ADDR_THR;
    wire logic hit_acal = paddr == tsc_pkg::ADDR_AUTOCAL;
    wire logic hit_idle = paddr == tsc_pkg::ADDR_IDLE;
    wire logic hit_act = paddr == tsc_pkg::ADDR_ACTIVE;
    wire logic hit_a2i = paddr == tsc_pkg::ADDR_A2I;
    wire logic hit_csum = paddr == tsc_pkg::ADDR_CSUM;
    wire logic hit_stat = paddr == tsc_pkg::ADDR_STATUS;
    wire logic mapped = |{hit_ctrl, hit_xen, hit_yen, hit_thr, hit_acal,
                          hit_idle, hit_act, hit_a2i, hit_csum, hit_stat};
    wire logic refuse = ~mapped | (~ready_reg & ~hit_stat);
    wire logic wr = access & pwrite & ~refuse;
    wire logic soft_rst_cmd = wr & hit_ctrl & pwdata[tsc_pkg::CTRL_SRST_BIT];
    wire logic recal_cmd = wr & hit_ctrl & pwdata[tsc_pkg::CTRL_RECAL_BIT];
    wire logic en_gain = (wr & hit_xen & (|(pwdata[15:0] & ~xen_reg)))
                       | (wr & hit_yen & (|(pwdata[13:0] & ~yen_reg)));
    assign flag_clr = (wr & hit_stat) ? pwdata[tsc_pkg::ST_FLAGS_W-1:0] : '0;

    assign status_word = {23'h00_0000, change_interrupt_n_in, ready_reg, active_reg,
                          burst_cal_reg, flag_reg};
    assign rd_data = hit_xen ? {16'h0000, xen_reg}
                   : hit_yen ? {18'h0_0000, yen_reg}
                   : hit_thr ? {24'h00_0000, thr_reg}
                   : hit_acal ? {24'h00_0000, autocal_reg}
                   : hit_idle ? {24'h00_0000, idle_reg}
                   : hit_act ? {24'h00_0000, active_reg_int}
                   : hit_a2i ? {24'h00_0000, a2i_reg}
                   : hit_csum ? {16'h0000, csum_reg}
                   : hit_stat ? status_word
                   : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = access & refuse;
    assign prdata = prdata_reg;

    // ------------------------------------------------------------
    // scan datapath
    // ------------------------------------------------------------
    wire logic [31:0] xmask = {16'h0000, scan_xen_reg};
    wire logic [31:0] ymask = {18'h0_0000, scan_yen_reg};
    wire logic [5:0] x_first = first_from({16'h0000, xen_reg}, 6'h00);
    wire logic [5:0] y_first = first_from({18'h0_0000, yen_reg}, 6'h00);
    wire logic [5:0] y_restart = first_from(ymask, 6'h00);
    wire logic [5:0] x_nx = first_from(xmask, 6'({1'b0, x_reg}) + 6'h01);
    wire logic [5:0] y_nx = first_from(ymask, 6'({1'b0, y_reg}) + 6'h01);
    wire logic in_wait = state_reg == tsc_pkg::S_WAIT;
    wire logic tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);
    wire logic boot_done = (state_reg == tsc_pkg::S_BOOT) & (boot_cnt_reg == 32'h0000_0001);
    wire logic burst_go = (state_reg == tsc_pkg::S_SLEEP) & (sleep_cnt_reg == 8'h00);
    wire logic go_ok = ~x_first[5] & ~y_first[5];
    wire logic line_over = in_wait & ~meas_valid
                         & (line_cnt_reg == 32'(XLINE_CYCLES - 1));
    wire logic step = in_wait & (meas_valid | line_over);
    wire logic adv_y = step & ~line_over & ~y_nx[5];
    wire logic adv_x = step & ~adv_y;
    wire logic burst_end = adv_x & x_nx[5];
    wire logic signed [15:0] thr_pos = signed'({8'h00, thr_reg});
    wire logic signed [15:0] thr_neg = 16'sh0000 - thr_pos;
    wire logic det = in_wait & meas_valid & (meas_delta >= thr_pos);
    wire logic anti = in_wait & meas_valid & (meas_delta <= thr_neg);
    wire logic touch_all = burst_touch_reg | det;
    wire logic anti_all = burst_anti_reg | anti;
    wire logic normal_end = burst_end & ~burst_cal_reg;
    wire logic autocal_hit = normal_end & touch_all & (autocal_reg != 8'h00)
                           & ((hold_cnt_reg + 8'h01) >= autocal_reg);
    wire logic anti_hit = normal_end & anti_all & ~touch_all;
    wire logic [15:0] cfg_sum = xen_reg ^ {2'b00, yen_reg} ^ {thr_reg, autocal_reg}
                              ^ {idle_reg, active_reg_int} ^ {8'h00, a2i_reg};
    wire logic cal_set = boot_done | en_gain | recal_cmd | autocal_hit | anti_hit;
    wire logic cal_take = burst_go & go_ok;
    wire logic a2i_expire = active_reg & (a2i_cnt_reg >= a2i_reg);
    wire logic mode_next = (burst_end & touch_all) | (active_reg & ~a2i_expire);

    assign flag_set[tsc_pkg::ST_RESET] = boot_done;
    assign flag_set[tsc_pkg::ST_CFGERR] = boot_done & (cfg_sum != csum_reg);
    assign flag_set[tsc_pkg::ST_CALSTART] = cal_take & cal_pend_reg;
    assign flag_set[tsc_pkg::ST_CALDONE] = burst_end & burst_cal_reg;
    assign flag_set[tsc_pkg::ST_OVERRUN] = line_over;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            tsc_pkg::S_BOOT: begin
                if (boot_done) begin
                    state_next = tsc_pkg::S_SLEEP;
                end
            end
            tsc_pkg::S_SLEEP: begin
                if (cal_take) begin
                    state_next = tsc_pkg::S_MEAS;
                end
            end
            tsc_pkg::S_MEAS: begin
                state_next = tsc_pkg::S_WAIT;
            end
            tsc_pkg::S_WAIT: begin
                if (burst_end) begin
                    state_next = tsc_pkg::S_SLEEP;
                end else if (step) begin
                    state_next = tsc_pkg::S_MEAS;
                end
            end
        endcase
        if (soft_rst_cmd) begin
            state_next = tsc_pkg::S_BOOT;
        end
    end

    // asynchronous reset catches any valid reset pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= tsc_pkg::S_BOOT;
            boot_cnt_reg <= 32'(BOOT_CYCLES);
            ready_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (soft_rst_cmd) begin
                boot_cnt_reg <= 32'(SOFT_CYCLES);
            end else if (state_reg == tsc_pkg::S_BOOT) begin
                boot_cnt_reg <= boot_cnt_reg - 32'h0000_0001;
            end
            ready_reg <= (ready_reg | boot_done) & ~soft_rst_cmd;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xen_reg <= tsc_pkg::XEN_RST;
            yen_reg <= tsc_pkg::YEN_RST;
            thr_reg <= tsc_pkg::THR_RST;
            autocal_reg <= tsc_pkg::AUTOCAL_RST;
            idle_reg <= tsc_pkg::IDLE_RST;
            active_reg_int <= tsc_pkg::ACTIVE_RST;
            a2i_reg <= tsc_pkg::A2I_RST;
            csum_reg <= tsc_pkg::CSUM_RST;
            prdata_reg <= 32'h0000_0000;
        end else begin
            if (wr & hit_xen) xen_reg <= pwdata[15:0];
            if (wr & hit_yen) yen_reg <= pwdata[13:0];
            if (wr & hit_thr) thr_reg <= pwdata[7:0];
            if (wr & hit_acal) autocal_reg <= pwdata[7:0];
            if (wr & hit_idle) idle_reg <= pwdata[7:0];
            if (wr & hit_act) active_reg_int <= pwdata[7:0];
            if (wr & hit_a2i) a2i_reg <= pwdata[7:0];
            if (wr & hit_csum) csum_reg <= pwdata[15:0];
            if (setup & ~pwrite) prdata_reg <= rd_data;
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= '0;
            cal_pend_reg <= 1'b0;
        end else begin
            flag_reg <= (flag_reg & ~flag_clr) | flag_set;
            cal_pend_reg <= (cal_pend_reg & ~cal_take) | cal_set;
        end
    end

    // X outer, Y inner; restart at first X
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_reg <= 5'h00;
            y_reg <= 5'h00;
            scan_xen_reg <= 16'h0000;
            scan_yen_reg <= 14'h0000;
            line_cnt_reg <= 32'h0000_0000;
        end else if (cal_take) begin
            x_reg <= x_first[4:0];
            y_reg <= y_first[4:0];
            scan_xen_reg <= xen_reg;
            scan_yen_reg <= yen_reg;
            line_cnt_reg <= 32'h0000_0000;
        end else if (adv_y) begin
            y_reg <= y_nx[4:0];
            line_cnt_reg <= line_cnt_reg + 32'h0000_0001;
        end else if (adv_x) begin
            x_reg <= x_nx[4:0];
            y_reg <= y_restart[4:0];
            line_cnt_reg <= 32'h0000_0000;
        end else if (state_reg[2] | state_reg[3]) begin
            line_cnt_reg <= line_cnt_reg + 32'h0000_0001;
        end
    end

    // whole burst is a global calibration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_cal_reg <= 1'b0;
            burst_touch_reg <= 1'b0;
            burst_anti_reg <= 1'b0;
            hold_cnt_reg <= 8'h00;
        end else begin
            if (cal_take) begin
                burst_cal_reg <= cal_pend_reg;
                burst_touch_reg <= 1'b0;
                burst_anti_reg <= 1'b0;
            end else begin
                burst_cal_reg <= burst_cal_reg & ~burst_end & ~soft_rst_cmd;
                burst_touch_reg <= touch_all;
                burst_anti_reg <= anti_all;
            end
            if (autocal_hit | (normal_end & ~touch_all)) begin
                hold_cnt_reg <= 8'h00;
            end else if (normal_end) begin
                hold_cnt_reg <= hold_cnt_reg + 8'h01;
            end
        end
    end

    // mode; burst then sleep in ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_reg <= 32'h0000_0000;
            sleep_cnt_reg <= 8'h00;
            active_reg <= 1'b0;
            a2i_cnt_reg <= 8'h00;
        end else begin
            tick_cnt_reg <= tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
            active_reg <= mode_next;
            if (burst_end) begin
                sleep_cnt_reg <= mode_next ? active_reg_int : idle_reg;
            end else if (burst_go & ~go_ok) begin
                sleep_cnt_reg <= active_reg ? active_reg_int : idle_reg;
            end else if (tick & (state_reg == tsc_pkg::S_SLEEP)) begin
                sleep_cnt_reg <= sleep_cnt_reg - 8'h01;
            end
            if (burst_end & touch_all) begin
                a2i_cnt_reg <= 8'h00;
            end else if (tick & active_reg & ~a2i_expire) begin
                a2i_cnt_reg <= a2i_cnt_reg + 8'h01;
            end
        end
    end

    // change pin is input-only for a while after hardware reset
    // a soft reset does not restart this window, so its completion can signal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chg_win_reg <= 32'(CHG_IN_CYCLES);
        end else if (chg_win_reg != 32'h0000_0000) begin
            chg_win_reg <= chg_win_reg - 32'h0000_0001;
        end
    end

    // open drain, pulled low while messages pend
    assign change_interrupt_n_out = 1'b0;
    assign change_interrupt_n_oe = (chg_win_reg == 32'h0000_0000)
                                 & (|flag_reg[tsc_pkg::ST_CALDONE:tsc_pkg::ST_RESET]);
    assign meas_req = state_reg == tsc_pkg::S_MEAS;
    assign meas_x = x_reg;
    assign meas_y = y_reg;
    assign meas_cal = burst_cal_reg;
    assign comm_ready = ready_reg;
    assign active_mode = active_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_scan_order: assert property (
        adv_y && !soft_rst_cmd |=> meas_req && (meas_x == $past(meas_x))
            && (meas_y > $past(meas_y)))
        else $error("y did not advance within the same x line");
    a_skip_disabled: assert property (
        meas_req |-> scan_xen_reg[meas_x[3:0]] && ymask[meas_y])
        else $error("disabled channel measured");
    a_boot_quiet: assert property (
        (state_reg == tsc_pkg::S_BOOT) |-> !comm_ready && !meas_req)
        else $error("ready or scanning during reset time");
    a_reset_flag: assert property (
        boot_done |=> comm_ready && flag_reg[tsc_pkg::ST_RESET])
        else $error("reset completion not flagged");
    a_chg_window: assert property (
        (chg_win_reg != 32'h0000_0000) |-> !change_interrupt_n_oe)
        else $error("change pin driven during input window");
    a_cal_msgs: assert property (
        (burst_end && burst_cal_reg) |=> flag_reg[tsc_pkg::ST_CALDONE] && !meas_cal)
        else $error("calibration completion not reported");
    a_cal_global: assert property (
        (cal_take && cal_pend_reg) |=> meas_cal[*2])
        else $error("calibration burst not marked");
    a_xline_limit: assert property (
        in_wait |-> (line_cnt_reg < 32'(XLINE_CYCLES)))
        else $error("x line exceeded its time limit");
    a_active_mode: assert property (
        (burst_end && touch_all) |=> active_mode ##1 active_mode)
        else $error("touch did not hold active mode");
    a_burst_start: assert property (
        cal_take && !soft_rst_cmd |=> meas_req && (meas_x == $past(x_first[4:0])))
        else $error("burst did not start at first enabled x");
endmodule : tsc_scan_ctrl

// File: testbench/tsc_meas_model.sv
`timescale 1ns/100ps
module tsc_meas_model (
    // clock, reset and request
    input wire logic pclk, presetn, meas_req,
    // bench control: stall while high, returned delta
    input wire logic mute,
    input wire logic signed [15:0] delta_set,
    // result
    output logic meas_valid,
    output logic signed [15:0] meas_delta
);
    logic [2:0] cnt;
    logic busy;
    // answer well inside line limit unless muted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {busy, cnt, meas_valid} <= '0;
            meas_delta <= 16'h0000;
        end else begin
            meas_valid <= busy && cnt == 0 && !mute;
            // delta only meaningful with valid, otherwise it toggles
            meas_delta <= (busy && cnt == 0 && !mute) ? delta_set : ~meas_delta;
            if (meas_req) {busy, cnt} <= {1'b1, 3'd3};
            else if (busy && cnt == 0) busy <= mute;
            else if (busy) cnt <= cnt - 3'd1;
        end
    end
endmodule : tsc_meas_model

// File: testbench/tsc_scan_ctrl_tb.sv
`timescale 1ns/100ps
module tsc_scan_ctrl_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mute = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata;
    logic signed [15:0] dset = 0, meas_delta;
    logic pready, pslverr, meas_req, meas_cal, meas_valid, oe, cout, comm_ready, active_mode;
    logic [4:0] meas_x, meas_y;
    logic [9:0] q[$];
    logic [9:0] pat[4] = '{10'h001, 10'h002, 10'h041, 10'h042};
    int failures = 0, check_count = 0, cyc = 0, t0, n, j, calcnt;
    // open-drain change line with its pull-up
    wire chg_pin = oe ? cout : 1'b1;
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) cyc++;
    always @(posedge pclk) if (meas_req === 1) begin
        q.push_back({meas_x, meas_y});
        if (meas_cal === 1) calcnt++;
    end
    tsc_scan_ctrl #(.BOOT_CYCLES(200), .SOFT_CYCLES(250), .CHG_IN_CYCLES(400),
        .XLINE_CYCLES(50), .TICK_CYCLES(10)) i_tsc_scan_ctrl (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .meas_req(meas_req), .meas_x(meas_x), .meas_y(meas_y), .meas_cal(meas_cal),
        .meas_valid(meas_valid), .meas_delta(meas_delta), .change_interrupt_n_in(chg_pin),
        .change_interrupt_n_out(cout), .change_interrupt_n_oe(oe),
        .comm_ready(comm_ready), .active_mode(active_mode));
    tsc_meas_model i_tsc_meas_model (.pclk(pclk), .presetn(presetn), .meas_req(meas_req),
        .mute(mute), .delta_set(dset), .meas_valid(meas_valid), .meas_delta(meas_delta));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        // outputs launched by the taking edge are looked at once settled
        #1;
    endtask : apb
    task automatic poll(input int b);
        for (int p = 0; p < 300 && (p == 0 || rd[b] !== 1); p++)
            apb(0, tsc_pkg::ADDR_STATUS, 0);
    endtask : poll
    task automatic wait_ready();
        for (int c = 0; c < 1000 && comm_ready !== 1; c++) @(posedge pclk) #1;
    endtask : wait_ready
    task automatic finish_test();
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test
    initial begin
        #(25 * 40000);
        failures++;
        finish_test();
    end
    initial begin
        // reset held low from power-up until the fourth rising clock edge, 87.5 ns
        repeat (4) @(posedge pclk);
        presetn <= 1;
        t0 = cyc;
        #1;
        apb(0, tsc_pkg::ADDR_XEN, 0);
        chk(er, 1);
        wait_ready();
        chk(cyc - t0 >= 199 && cyc - t0 <= 201, 1);
        apb(0, tsc_pkg::ADDR_THR, 0);
        chk(rd, tsc_pkg::THR_RST);
        apb(0, 12'h100, 0);
        chk(er, 1);
        chk(rd, 0);
        apb(0, tsc_pkg::ADDR_STATUS, 0);
        chk({rd[8], rd[1:0], oe}, 4'b1010);
        apb(1, tsc_pkg::ADDR_IDLE, 2);
        apb(1, tsc_pkg::ADDR_ACTIVE, 1);
        // timeout longer than a burst, so steady touch keeps active mode
        apb(1, tsc_pkg::ADDR_A2I, 8);
        apb(1, tsc_pkg::ADDR_XEN, 32'h0000_0005);
        apb(1, tsc_pkg::ADDR_YEN, 32'h0000_0006);
        poll(3);
        chk(rd[3], 1);
        while (cyc - t0 < 410) @(posedge pclk) #1;
        apb(0, tsc_pkg::ADDR_STATUS, 0);
        chk({oe, cout, rd[8]}, 3'b100);
        apb(1, tsc_pkg::ADDR_STATUS, 32'h0000_001F);
        chk(oe, 0);
        q.delete();
        repeat (150) @(posedge pclk) #1;
        for (j = 0; q[j] !== 10'h001 && j < 8; j++);
        for (int k = 0; k < 8; k++) chk(q[j + k], pat[k % 4]);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) @(posedge pclk) dset <= -16'sd64;
            if (k == 3) apb(1, tsc_pkg::ADDR_AUTOCAL, 3);
            if (k == 3) @(posedge pclk) dset <= 16'sd64;
            // calibrations from the previous step must run out first
            repeat (200) @(posedge pclk);
            apb(1, tsc_pkg::ADDR_STATUS, 32'h0000_001F);
            calcnt = 0;
            if (k == 0) apb(1, tsc_pkg::ADDR_XEN, 32'h0000_0007);
            if (k == 1) apb(1, tsc_pkg::ADDR_CTRL, 32'h0000_0002);
            poll(2);
            poll(3);
            chk(rd[3:2], 2'b11);
            if (k == 1) chk(calcnt, 6);
        end
        chk(active_mode, 1);
        apb(1, tsc_pkg::ADDR_AUTOCAL, 0);
        @(posedge pclk) dset <= 0;
        for (n = 0; n < 500 && active_mode !== 0; n++) @(posedge pclk) #1;
        chk(n >= 15 && n < 300, 1);
        @(posedge pclk) mute <= 1;
        poll(4);
        chk(rd[4], 1);
        @(posedge pclk) mute <= 0;
        apb(1, tsc_pkg::ADDR_STATUS, 32'h0000_001F);
        apb(1, tsc_pkg::ADDR_CTRL, 32'h0000_0001);
        t0 = cyc;
        chk(comm_ready, 0);
        wait_ready();
        chk(cyc - t0 >= 248 && cyc - t0 <= 252, 1);
        apb(0, tsc_pkg::ADDR_STATUS, 0);
        chk({rd[1:0], oe}, 3'b111);
        finish_test();
    end
endmodule : tsc_scan_ctrl_tb
